// ### common/srp_pkg.sv
// constants, register map and helpers for the serial register port
// assumes one 100 MHz system clock shared by every user of this package
package srp_pkg;

   // command byte layout
   localparam int           CMD_WRITE_BIT  = 7;
   localparam int           BYTE_BITS      = 8;
   localparam logic [2:0]   LAST_BIT_IDX   = 3'h7;

   // register map
   localparam logic [6:0]   ADDR_OPERATING_CONTROL        = 7'h13;
   localparam logic [6:0]   ADDR_INTERRUPT_ENABLE_MASK    = 7'h18;
   localparam logic [6:0]   ADDR_INTERRUPT_FLAGS          = 7'h19;
   localparam logic [6:0]   ADDR_FLAGS_READ_WITH_CLEAR    = 7'h1A;

   localparam int           FLAG_W          = 24;
   localparam int           SOFT_RESET_BIT  = 6;
   localparam int           RESET_FLAG_BIT  = 19;

   // values after reset, and the mask of the reset-event flag
   localparam logic [23:0]  MASK_RESET      = 24'h000000;
   localparam logic [23:0]  FLAGS_RESET     = 24'h000000;
   localparam logic [7:0]   OPCTL_RESET     = 8'h00;
   localparam logic [23:0]  RESET_FLAG_MASK = 24'h080000;

   // host-side spacing, in time and in system clock cycles
   localparam int           CLK_PERIOD_NS   = 10;
   localparam int           BYTE_GAP_NS     = 900;
   localparam int           BYTE_GAP_CYC    = (BYTE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int           WR_TO_RD_NS     = 1100;
   localparam int           WR_TO_RD_CYC    = (WR_TO_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      SRP_CMD = 2'h0,
      SRP_WR  = 2'h1,
      SRP_RD  = 2'h2
   } srp_phase_e;

   // data bytes carried by a transfer to this address
   function automatic logic [1:0] srp_reg_bytes(input logic [6:0] a);
      if (a == ADDR_INTERRUPT_ENABLE_MASK || a == ADDR_INTERRUPT_FLAGS ||
          a == ADDR_FLAGS_READ_WITH_CLEAR) begin
         return 2'h3;
      end
      return 2'h1;
   endfunction : srp_reg_bytes

   // write one received byte into lane of a register, right justified
   function automatic logic [23:0] srp_put_byte(input logic [23:0] old,
                                                input logic [1:0]  lane,
                                                input logic [7:0]  b);
      logic [23:0] r;
      r = old;
      r[8 * lane +: 8] = b;
      return r;
   endfunction : srp_put_byte

endpackage : srp_pkg

// ### testbench/srp_host.sv
// host model: serial bus master for the register port
// assumes clk is the 100 MHz system clock; sclk idles high between frames
`timescale 1ns/1ps
module srp_host (
   input  wire logic clk,
   input  wire logic dout_w,
   input  wire logic dout_oe,
   input  wire logic irq_n,
   output logic      sclk,
   output logic      din,
   output logic      cs_n
);
   logic irq_high_all;
   logic oe_end;
   logic oe_late;

   initial begin
      sclk = 1'b1;
      din = 1'b0;
      cs_n = 1'b1;
      irq_high_all = 1'b1;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask : hold

   // command then nb data bytes, msb first; cut > 0 raises cs_n after that many bits
   task automatic xfer(input logic [7:0] cmd, input int nb, input logic [23:0] wd,
                       input int cut, output logic [23:0] rd);
      logic [31:0] sh;
      sh = {cmd, wd << (8 * (3 - nb))};
      rd = '0;
      irq_high_all = 1'b1;
      cs_n = 1'b0;
      hold(4);
      for (int i = 0; i < 8 + 8 * nb; i++) begin
         if (cut != 0 && i == cut) break;
         din = sh[31-i];
         hold(4);
         sclk = 1'b0;
         hold(1);
         if (i >= 8) begin
            rd = {rd[22:0], dout_w};
            irq_high_all &= irq_n;
         end
         hold(3);
         sclk = 1'b1;
         if (cmd[7] && i % 8 == 7) hold(100);
      end
      hold(4);
      oe_end = dout_oe;
      cs_n = 1'b1;
      hold(8);
      oe_late = dout_oe;
      hold(112);
   endtask : xfer
endmodule : srp_host

// ### testbench/tb_top.sv
// self-checking bench for the serial register port
// assumes srp_pkg is compiled first; the host model drives the serial pins
`timescale 1ns/1ps
module tb_top;
   import srp_pkg::*;
   logic              clk, rst, sclk, din, cs_n, dout, dout_oe, irq_n;
   logic              last_dout = 1'b0;
   logic [FLAG_W-1:0] event_in;
   logic [7:0]        operating_control;
   logic [23:0]       rd, mask_v, ev_v, ev2_v;
   int                seed = 35900;
   int                miscompares = 0;
   int                checks_done = 0;
   int                cyc = 0;
   int                b;
   // released line shows the inverse of its last driven value
   wire               dout_w = dout_oe ? dout : ~last_dout;

   srp_port u_srp_port (.clk(clk), .rst(rst), .sclk(sclk), .din(din), .cs_n(cs_n),
      .event_in(event_in), .dout(dout), .dout_oe(dout_oe), .irq_n(irq_n),
      .operating_control(operating_control));
   srp_host u_srp_host (.clk(clk), .dout_w(dout_w), .dout_oe(dout_oe), .irq_n(irq_n),
      .sclk(sclk), .din(din), .cs_n(cs_n));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (dout_oe) last_dout <= dout;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         miscompares++;
         end_sim();
      end
   end

   function automatic logic exp_irq(input logic [23:0] f, input logic [23:0] m);
      return ~|(f & m);
   endfunction : exp_irq

   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic rdreg(input logic [6:0] a, input int nb);
      u_srp_host.xfer({1'b0, a}, nb, 24'h000000, 0, rd);
   endtask : rdreg

   task automatic wrreg(input logic [6:0] a, input int nb, input logic [23:0] v);
      u_srp_host.xfer({1'b1, a}, nb, v, 0, rd);
   endtask : wrreg

   task automatic pulse(input logic [23:0] v);
      @(negedge clk) event_in = v;
      @(negedge clk) event_in = '0;
      repeat (4) @(negedge clk);
   endtask : pulse

   task automatic end_sim;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   initial begin
      rst = 1'b1;
      event_in = '0;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      cmp(irq_n, 1'b1);
      cmp(operating_control, OPCTL_RESET);
      rdreg(ADDR_INTERRUPT_FLAGS, 3);
      cmp(rd, FLAGS_RESET);
      rdreg(ADDR_INTERRUPT_ENABLE_MASK, 3);
      cmp(rd, MASK_RESET);
      cmp(u_srp_host.oe_end, 1'b0);
      for (int k = 0; k < 3; k++) begin
         mask_v = 24'($random(seed));
         wrreg(ADDR_INTERRUPT_ENABLE_MASK, 3, mask_v);
         rdreg(ADDR_INTERRUPT_ENABLE_MASK, 3);
         cmp(rd, mask_v);
      end
      // cut inside the second data byte: first byte lands, second is dropped
      u_srp_host.xfer({1'b1, ADDR_INTERRUPT_ENABLE_MASK}, 3, ~mask_v, 20, rd);
      rdreg(ADDR_INTERRUPT_ENABLE_MASK, 3);
      cmp(rd, {~mask_v[23:16], mask_v[15:0]});
      u_srp_host.xfer({1'b0, ADDR_INTERRUPT_ENABLE_MASK}, 3, 24'h000000, 14, rd);
      cmp(u_srp_host.oe_late, 1'b0);
      wrreg(ADDR_INTERRUPT_ENABLE_MASK, 3, 24'h000000);
      b = $unsigned($random(seed)) % 23;
      if (b >= RESET_FLAG_BIT) b++;
      ev_v = 24'h000001 << b;
      pulse(ev_v);
      cmp(irq_n, exp_irq(ev_v, 24'h000000));
      rdreg(ADDR_INTERRUPT_FLAGS, 3);
      cmp(rd, ev_v);
      wrreg(ADDR_INTERRUPT_ENABLE_MASK, 3, ev_v);
      cmp(irq_n, exp_irq(ev_v, ev_v));
      rdreg(ADDR_FLAGS_READ_WITH_CLEAR, 3);
      cmp(rd, ev_v);
      cmp(irq_n, 1'b1);
      rdreg(ADDR_INTERRUPT_FLAGS, 3);
      cmp(rd, 24'h000000);
      pulse(ev_v);
      fork
         rdreg(ADDR_FLAGS_READ_WITH_CLEAR, 3);
         begin
            repeat (150) @(negedge clk);
            pulse(ev_v);
         end
      join
      cmp(rd, ev_v);
      cmp(u_srp_host.irq_high_all, 1'b1);
      cmp(irq_n, 1'b0);
      // a new event mid-read must not reach the copy already taken
      ev2_v = (b == 0) ? 24'h000002 : 24'h000001;
      fork
         rdreg(ADDR_INTERRUPT_FLAGS, 3);
         begin
            repeat (150) @(negedge clk);
            pulse(ev2_v);
         end
      join
      cmp(rd, ev_v);
      rdreg(ADDR_INTERRUPT_FLAGS, 3);
      cmp(rd, ev_v | ev2_v);
      wrreg(ADDR_OPERATING_CONTROL, 1, 24'h000015);
      cmp(operating_control, 8'h15);
      rdreg(ADDR_OPERATING_CONTROL, 1);
      cmp(rd, 24'h000015);
      wrreg(ADDR_OPERATING_CONTROL, 1, 24'h000040);
      cmp(operating_control[SOFT_RESET_BIT], 1'b0);
      cmp(irq_n, 1'b1);
      rdreg(ADDR_INTERRUPT_ENABLE_MASK, 3);
      cmp(rd, MASK_RESET);
      rdreg(7'h05, 1);
      cmp(rd, 24'h000000);
      end_sim();
   end
endmodule : tb_top

// ### verilog/srp_port.sv
// serial register port with interrupt request logic
// assumes sclk, din and cs_n come from pins, event_in from logic on clk
`timescale 1ns/1ps

module srp_port (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        sclk,
   input  wire logic                        din,
   input  wire logic                        cs_n,
   input  wire logic [srp_pkg::FLAG_W-1:0]  event_in,
   output logic                             dout,
   output logic                             dout_oe,
   output logic                             irq_n,
   output logic [7:0]                       operating_control
);
   import srp_pkg::*;

   typedef struct packed {
      logic        sclk_m;
      logic        sclk_s;
      logic        sclk_d;
      logic        din_m;
      logic        din_s;
      logic        cs_m;
      logic        cs_s;
      srp_phase_e  phase;
      logic [2:0]  bit_cnt;
      logic [1:0]  byte_cnt;
      logic [1:0]  nbytes;
      logic [6:0]  addr;
      logic [23:0] shift;
      logic        dout;
      logic        oe;
      logic [23:0] mask;
      logic [23:0] flags;
      logic [7:0]  opctl;
      logic        irq_hold;
      logic        irq_n;
      logic        boot;
   } srp_state_s;

   srp_state_s  state_reg;
   srp_state_s  state_next;

   logic        fall;
   logic        rise;
   logic [7:0]  rx_byte;
   logic        byte_end;
   logic        cmd_end;
   logic        xfer_end;
   logic        clear_flags;
   logic [1:0]  lane;
   logic [23:0] rd_value;
   logic [1:0]  cmd_bytes;

   assign fall        = state_reg.sclk_d & ~state_reg.sclk_s;
   assign rise        = ~state_reg.sclk_d & state_reg.sclk_s;
   assign rx_byte     = {state_reg.shift[6:0], state_reg.din_s};
   assign byte_end    = fall && !state_reg.cs_s && state_reg.bit_cnt == LAST_BIT_IDX;
   assign cmd_end     = byte_end && state_reg.phase == SRP_CMD;
   assign xfer_end    = byte_end && state_reg.phase != SRP_CMD &&
                        state_reg.byte_cnt == 2'(state_reg.nbytes - 2'h1);
   assign clear_flags = cmd_end && !rx_byte[CMD_WRITE_BIT] &&
                        rx_byte[6:0] == ADDR_FLAGS_READ_WITH_CLEAR;
   assign lane        = 2'(state_reg.nbytes - 2'h1 - state_reg.byte_cnt);
   assign cmd_bytes   = srp_reg_bytes(rx_byte[6:0]);

   // value of the addressed register at command end
   always_comb begin
      rd_value = 24'h000000;
      if (rx_byte[6:0] == ADDR_INTERRUPT_ENABLE_MASK) begin
         rd_value = state_reg.mask;
      end else if (rx_byte[6:0] == ADDR_INTERRUPT_FLAGS ||
                   rx_byte[6:0] == ADDR_FLAGS_READ_WITH_CLEAR) begin
         rd_value = state_reg.flags;
      end else if (rx_byte[6:0] == ADDR_OPERATING_CONTROL) begin
         rd_value = {16'h0000, state_reg.opctl};
      end
   end

   always_comb begin
      state_next = state_reg;
      // pin synchronisers
      state_next.sclk_m = sclk;
      state_next.sclk_s = state_reg.sclk_m;
      state_next.sclk_d = state_reg.sclk_s;
      state_next.din_m  = din;
      state_next.din_s  = state_reg.din_m;
      state_next.cs_m   = cs_n;
      state_next.cs_s   = state_reg.cs_m;

      // flags: clear first, then events, so a coincident event survives
      state_next.flags = clear_flags ? FLAGS_RESET : state_reg.flags;
      state_next.flags = (state_next.flags | event_in) & ~RESET_FLAG_MASK;
      state_next.flags[RESET_FLAG_BIT] = state_reg.boot;
      state_next.boot  = 1'b0;

      state_next.irq_n = ~(|(state_reg.flags & state_reg.mask)) | state_reg.irq_hold;

      // soft reset clears itself and raises the reset-event flag
      state_next.opctl[SOFT_RESET_BIT] = 1'b0;
      if (state_reg.opctl[SOFT_RESET_BIT]) begin
         state_next.boot = 1'b1;
         state_next.mask = MASK_RESET;
      end

      if (state_reg.cs_s || state_reg.opctl[SOFT_RESET_BIT]) begin
         // abort or idle: partial byte dropped, dout released
         state_next.phase    = SRP_CMD;
         state_next.bit_cnt  = 3'h0;
         state_next.byte_cnt = 2'h0;
         state_next.oe       = 1'b0;
         state_next.irq_hold = 1'b0;
      end else begin
         if (fall) begin
            state_next.bit_cnt = 3'(state_reg.bit_cnt + 3'h1);
            if (state_reg.phase != SRP_RD) begin
               state_next.shift = {state_reg.shift[22:0], state_reg.din_s};
            end
         end
         unique case (state_reg.phase)
            SRP_CMD: begin
               if (cmd_end) begin
                  state_next.addr     = rx_byte[6:0];
                  state_next.nbytes   = cmd_bytes;
                  state_next.byte_cnt = 2'h0;
                  if (rx_byte[CMD_WRITE_BIT]) begin
                     state_next.phase = SRP_WR;
                  end else begin
                     state_next.phase = SRP_RD;
                     // whole register copied, left aligned to the buffer top
                     state_next.shift = rd_value << (8 * (3 - cmd_bytes));
                     state_next.irq_hold = clear_flags;
                  end
               end
            end
            SRP_WR: begin
               if (byte_end) begin
                  state_next.byte_cnt = 2'(state_reg.byte_cnt + 2'h1);
                  // first byte lands in the top lane of the register
                  if (state_reg.addr == ADDR_INTERRUPT_ENABLE_MASK) begin
                     state_next.mask = srp_put_byte(state_reg.mask, lane, rx_byte);
                  end else if (state_reg.addr == ADDR_OPERATING_CONTROL) begin
                     state_next.opctl = rx_byte;
                  end
                  if (xfer_end) begin
                     state_next.phase = SRP_CMD;
                  end
               end
            end
            SRP_RD: begin
               if (rise) begin
                  state_next.oe    = 1'b1;
                  state_next.dout  = state_reg.shift[23];
                  state_next.shift = {state_reg.shift[22:0], 1'b0};
               end
               if (byte_end) begin
                  state_next.byte_cnt = 2'(state_reg.byte_cnt + 2'h1);
                  if (xfer_end) begin
                     state_next.phase    = SRP_CMD;
                     state_next.oe       = 1'b0;
                     state_next.irq_hold = 1'b0;
                  end
               end
            end
            default: begin
               state_next.phase = SRP_CMD;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg          <= '0;
         state_reg.sclk_m   <= 1'b0;
         state_reg.cs_m     <= 1'b1;
         state_reg.cs_s     <= 1'b1;
         state_reg.phase    <= SRP_CMD;
         state_reg.nbytes   <= 2'h1;
         state_reg.mask     <= MASK_RESET;
         state_reg.flags    <= FLAGS_RESET;
         state_reg.opctl    <= OPCTL_RESET;
         state_reg.irq_n    <= 1'b1;
         state_reg.boot     <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign dout              = state_reg.dout;
   assign dout_oe           = state_reg.oe;
   assign irq_n             = state_reg.irq_n;
   assign operating_control = state_reg.opctl;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_flag_sets_unmasked: assert property (
      (|(event_in & ~RESET_FLAG_MASK)) |=>
         ((state_reg.flags & $past(event_in & ~RESET_FLAG_MASK)) ==
          $past(event_in & ~RESET_FLAG_MASK)))
      else $error("event did not set its flag");

   a_irq_low_pending: assert property (
      (|(state_reg.flags & state_reg.mask) && !state_reg.irq_hold) |=> !irq_n)
      else $error("irq not asserted for enabled flag");

   a_irq_high_idle: assert property (
      (!(|(state_reg.flags & state_reg.mask))) |=> irq_n)
      else $error("irq asserted with nothing pending");

   a_clear_on_read: assert property (
      clear_flags |=> ((state_reg.flags & ~$past(event_in) & ~RESET_FLAG_MASK) == 24'h000000))
      else $error("flags not cleared by clear-on-read");

   a_irq_held_transfer: assert property (
      state_reg.irq_hold |=> irq_n)
      else $error("irq low during status transfer");

   a_hold_at_cmd: assert property (
      clear_flags && !state_reg.cs_s |=> state_reg.irq_hold ##1 irq_n)
      else $error("irq not released at status command");

   a_reset_flag_pulse: assert property (
      state_reg.flags[RESET_FLAG_BIT] |=> !state_reg.flags[RESET_FLAG_BIT])
      else $error("reset flag longer than one cycle");

   a_dout_on_rise: assert property (
      !$stable(dout) |-> $past(rise))
      else $error("dout changed away from a rising edge");

   a_cs_high_release: assert property (
      state_reg.cs_s |=> (!dout_oe && state_reg.phase == SRP_CMD))
      else $error("dout driven or transfer kept after cs high");

   a_cmd_after_last: assert property (
      xfer_end |=> (state_reg.phase == SRP_CMD && !dout_oe))
      else $error("port not back in command mode after last bit");

   a_oe_only_read: assert property (
      dout_oe |-> state_reg.phase == SRP_RD)
      else $error("dout driven outside a read");

   // soft reset drops any transfer in flight and clears the mask
   a_soft_reset_cmd: assert property (
      state_reg.opctl[SOFT_RESET_BIT] |=>
         (state_reg.phase == SRP_CMD && state_reg.mask == MASK_RESET && !dout_oe))
      else $error("soft reset did not return the port to command mode");

   a_soft_reset_flag: assert property (
      state_reg.opctl[SOFT_RESET_BIT] |=> ##1 state_reg.flags[RESET_FLAG_BIT])
      else $error("soft reset did not pulse the reset-event flag");

   // the mask only moves on a whole received byte or a soft reset
   a_mask_whole_byte: assert property (
      !$stable(state_reg.mask) |->
         $past((byte_end && state_reg.phase == SRP_WR) || state_reg.opctl[SOFT_RESET_BIT]))
      else $error("mask changed without a complete write byte");

   a_cmd_selects_dir: assert property (
      cmd_end |=>
         state_reg.phase == ($past(rx_byte[CMD_WRITE_BIT]) ? SRP_WR : SRP_RD))
      else $error("command byte did not select the transfer direction");

   a_cs_clears_count: assert property (
      state_reg.cs_s |=> (state_reg.bit_cnt == 3'h0 && state_reg.byte_cnt == 2'h0))
      else $error("bit or byte count kept while deselected");

   a_hold_only_clear: assert property (
      state_reg.irq_hold |->
         (state_reg.phase == SRP_RD && state_reg.addr == ADDR_FLAGS_READ_WITH_CLEAR))
      else $error("irq held outside a clear-on-read transfer");

   c_read_clear: cover property (clear_flags ##[1:600] xfer_end);
   c_mask_write: cover property (xfer_end && state_reg.phase == SRP_WR &&
                                 state_reg.addr == ADDR_INTERRUPT_ENABLE_MASK);
   c_read_abort: cover property (state_reg.phase == SRP_RD && dout_oe ##1 state_reg.cs_s);
   c_event_during_hold: cover property (state_reg.irq_hold && |event_in);
   c_soft_reset: cover property (state_reg.opctl[SOFT_RESET_BIT] ##2
                                 state_reg.flags[RESET_FLAG_BIT]);

endmodule : srp_port
